// >>> logic/bzcfg_top.sv
// bioz channel configuration registers, threshold compare and lead-off qualifying
// Overview of operation
// - bias enable powers channel bias; ready flag after the settle time
// - quadrature enable turns on drive, q receive, forces pll and bias
// - in-phase enable turns on drive, i receive, forces pll and bias
// - high-pass code 0 bypass, 1 low cutoff, 2 and 3 high cutoff
// - low-pass code 0 bypass, 1 to 3 cutoffs, 4 to 7 widest cutoff
// - compare source picks |i|, |q| or magnitude; code 3 reserved
// - a disabled channel reads zero, so magnitude equals the other
// - when enabled, compare selected value to upper and lower limits
// - comparison result sets status bit 6 above, bit 5 below
// - threshold enable low means no compare and no flag update
// - internal resistor: current from voltage level and current range
// - voltage level at bits 5:4, current range at bits 3:2
// - internal resistor: hardware may overwrite level and range for safety
// - external resistor: voltage level never overwritten automatically
// - normal lead-off status only after condition persists the window
// - fast disconnect bypasses the window, status at once
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "bzcfg_map.svh"
module bzcfg_top #(
  parameter int DATA_W = bzcfg_pkg::BZCFG_DATA_W,
  parameter int TICK_CYCLES = `BZ_TICK_CYCLES,
  parameter int BIAS_SETTLE_TICKS = `BZ_BIAS_SETTLE_TICKS,
  parameter int LOFF_WINDOW_TICKS = `BZ_LOFF_WINDOW_TICKS
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_sample_valid,
  input wire logic signed [DATA_W-1:0] i_sample_i,
  input wire logic signed [DATA_W-1:0] i_sample_q,
  input wire logic i_leadoff_raw,
  input wire logic i_safe_valid,
  input wire logic [1:0] i_safe_voltage_level,
  input wire logic [1:0] i_safe_current_range,
  output logic o_bias_ref_on,
  output logic o_bias_ready,
  output logic o_pll_force_on,
  output logic o_drive_enable,
  output logic o_inphase_rx_enable,
  output logic o_quad_rx_enable,
  output bzcfg_pkg::bzcfg_hp_cut_t o_hipass_cutoff,
  output bzcfg_pkg::bzcfg_lp_cut_t o_lopass_cutoff,
  output logic [2:0] o_converter_oversample_sel,
  output logic [1:0] o_dac_oversample_sel,
  output logic [1:0] o_drive_voltage_level,
  output logic [1:0] o_drive_current_range,
  output logic [1:0] o_stimulus_type_sel,
  output logic o_external_resistor_sel,
  output logic o_dc_leadoff_status,
  output logic o_irq
);
  import bzcfg_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam int BIAS_W = $clog2(BIAS_SETTLE_TICKS + 1);
  localparam logic [BIAS_W-1:0] BIAS_END = BIAS_W'(BIAS_SETTLE_TICKS);

  bzcfg_byte_t cfg1_reg;
  bzcfg_byte_t cfg2_reg;
  bzcfg_byte_t cfg3_reg;
  bzcfg_byte_t lo_thr_reg;
  bzcfg_byte_t hi_thr_reg;
  bzcfg_byte_t mask_reg;
  bzcfg_byte_t status_reg;
  bzcfg_byte_t status_next;
  bzcfg_byte_t status_set;
  bzcfg_byte_t status_clr;
  logic [31:0] prdata_reg;
  logic [9:0] reg_idx;
  logic addr_hit;
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic rd_status;
  logic [TICK_W-1:0] tick_cnt_reg;
  logic tick;
  logic [BIAS_W-1:0] bias_cnt_reg;
  logic bias_ready_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic leadoff_lvl_reg;
  logic leadoff_status;
  logic leadoff_status_d_reg;
  logic [7:0] cmp_value;
  logic above;
  logic below;
  logic cmp_valid;
  logic inphase_en;
  logic quad_en;
  logic bias_en;
  logic thr_en;
  logic ext_res;
  bzcfg_cmp_src_t cmp_src;

  assign inphase_en = cfg1_reg[`BZ_C1_INPHASE_EN];
  assign quad_en = cfg1_reg[`BZ_C1_QUAD_EN];
  assign bias_en = cfg1_reg[`BZ_C1_BIAS_EN];
  assign thr_en = cfg2_reg[`BZ_C2_THR_EN];
  assign cmp_src = bzcfg_cmp_src_t'(cfg2_reg[`BZ_C2_CMP_LSB +: 2]);
  assign ext_res = cfg3_reg[`BZ_C3_EXT_RES];

  // apb slave: zero wait states, read data captured in the setup cycle
  assign reg_idx = i_paddr[11:2];
  assign setup_phase = i_psel && !i_penable;
  assign access_phase = i_psel && i_penable;
  assign wr_access = access_phase && i_pwrite && addr_hit;
  assign rd_status = access_phase && !i_pwrite && (reg_idx == `BZ_IDX_STATUS);
  assign o_pready = 1'b1;
  assign o_pslverr = access_phase && !addr_hit;
  assign o_prdata = prdata_reg;

  always_comb begin
    case (reg_idx)
      `BZ_IDX_STATUS, `BZ_IDX_MASK, `BZ_IDX_CFG1, `BZ_IDX_CFG2,
      `BZ_IDX_CFG3, `BZ_IDX_LO_THR, `BZ_IDX_HI_THR: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_phase && !i_pwrite) begin
      case (reg_idx)
        `BZ_IDX_STATUS: prdata_reg <= {24'h00_0000, status_reg};
        `BZ_IDX_MASK: prdata_reg <= {24'h00_0000, mask_reg};
        `BZ_IDX_CFG1: prdata_reg <= {24'h00_0000, cfg1_reg};
        `BZ_IDX_CFG2: prdata_reg <= {24'h00_0000, cfg2_reg};
        `BZ_IDX_CFG3: prdata_reg <= {24'h00_0000, cfg3_reg};
        `BZ_IDX_LO_THR: prdata_reg <= {24'h00_0000, lo_thr_reg};
        `BZ_IDX_HI_THR: prdata_reg <= {24'h00_0000, hi_thr_reg};
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // software-written configuration
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cfg1_reg <= `BZ_RST_CFG1;
      cfg2_reg <= `BZ_RST_CFG2;
      lo_thr_reg <= `BZ_RST_LO_THR;
      hi_thr_reg <= `BZ_RST_HI_THR;
      mask_reg <= `BZ_RST_MASK;
    end else if (wr_access) begin
      case (reg_idx)
        `BZ_IDX_CFG1: cfg1_reg <= i_pwdata[7:0];
        `BZ_IDX_CFG2: cfg2_reg <= i_pwdata[7:0];
        `BZ_IDX_LO_THR: lo_thr_reg <= i_pwdata[7:0];
        `BZ_IDX_HI_THR: hi_thr_reg <= i_pwdata[7:0];
        `BZ_IDX_MASK: mask_reg <= i_pwdata[7:0];
        default: ;
      endcase
    end
  end

  // drive config; safety overwrite wins over a software write in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cfg3_reg <= `BZ_RST_CFG3;
    end else if (i_safe_valid && !ext_res) begin
      cfg3_reg[`BZ_C3_VMAG_LSB +: 2] <= i_safe_voltage_level;
      cfg3_reg[`BZ_C3_IRGE_LSB +: 2] <= i_safe_current_range;
    end else if (wr_access && (reg_idx == `BZ_IDX_CFG3)) begin
      cfg3_reg <= i_pwdata[7:0];
    end
  end

  // 1 ms enable pulse shared by the bias settle and lead-off timers
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tick_cnt_reg <= '0;
    end else if (tick_cnt_reg == TICK_LAST) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end
  assign tick = (tick_cnt_reg == TICK_LAST);

  // bias settle timer, restarted whenever the bias turns off
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      bias_cnt_reg <= '0;
      bias_ready_reg <= 1'b0;
    end else if (!o_bias_ref_on) begin
      bias_cnt_reg <= '0;
      bias_ready_reg <= 1'b0;
    end else if (bias_cnt_reg == BIAS_END) begin
      bias_ready_reg <= 1'b1;
    end else if (tick) begin
      bias_cnt_reg <= bias_cnt_reg + 1'b1;
    end
  end

  // channel power and path control, registered from the configuration
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_bias_ref_on <= 1'b0;
      o_pll_force_on <= 1'b0;
      o_drive_enable <= 1'b0;
      o_inphase_rx_enable <= 1'b0;
      o_quad_rx_enable <= 1'b0;
    end else begin
      o_bias_ref_on <= bias_en || inphase_en || quad_en;
      o_pll_force_on <= inphase_en || quad_en;
      o_drive_enable <= inphase_en || quad_en;
      o_inphase_rx_enable <= inphase_en;
      o_quad_rx_enable <= quad_en;
    end
  end

  // filter cutoff decode and drive fields
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_hipass_cutoff <= BZCFG_HP_BYPASS;
      o_lopass_cutoff <= BZCFG_LP_BYPASS;
    end else begin
      case (cfg2_reg[`BZ_C2_HPF_LSB +: 2])
        2'h0: o_hipass_cutoff <= BZCFG_HP_BYPASS;
        2'h1: o_hipass_cutoff <= BZCFG_HP_X0P00025;
        default: o_hipass_cutoff <= BZCFG_HP_X0P002;
      endcase
      case (cfg2_reg[`BZ_C2_LPF_LSB +: 3])
        3'h0: o_lopass_cutoff <= BZCFG_LP_BYPASS;
        3'h1: o_lopass_cutoff <= BZCFG_LP_X0P005;
        3'h2: o_lopass_cutoff <= BZCFG_LP_X0P02;
        3'h3: o_lopass_cutoff <= BZCFG_LP_X0P08;
        default: o_lopass_cutoff <= BZCFG_LP_X0P25;
      endcase
    end
  end

  assign o_converter_oversample_sel = cfg1_reg[`BZ_C1_ADC_OSR_LSB +: 3];
  assign o_dac_oversample_sel = cfg1_reg[`BZ_C1_DAC_OSR_LSB +: 2];
  assign o_drive_voltage_level = cfg3_reg[`BZ_C3_VMAG_LSB +: 2];
  assign o_drive_current_range = cfg3_reg[`BZ_C3_IRGE_LSB +: 2];
  assign o_stimulus_type_sel = cfg3_reg[`BZ_C3_MODE_LSB +: 2];
  assign o_external_resistor_sel = ext_res;
  assign o_bias_ready = bias_ready_reg;

  // lead-off pin: three-stage synchroniser, a change counts when stages 2 and 3 agree
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      leadoff_lvl_reg <= 1'b0;
    end else begin
      sync1_reg <= i_leadoff_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) begin
        leadoff_lvl_reg <= sync3_reg;
      end
    end
  end

  bzcfg_debounce #(
    .WINDOW_TICKS(LOFF_WINDOW_TICKS)
  ) u_debounce (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_tick(tick),
    .i_level(leadoff_lvl_reg),
    .i_rapid(cfg3_reg[`BZ_C3_RAPID]),
    .o_status(leadoff_status)
  );
  assign o_dc_leadoff_status = leadoff_status;

  // threshold compare on each new sample that arrives while the magnitude engine is idle; disabled channel data forced to zero
  bzcfg_calc_if #(.DATA_W(DATA_W)) calc_bus ();

  assign calc_bus.start = i_sample_valid && thr_en && (cmp_src != BZCFG_CMP_RSVD);
  assign calc_bus.i_data = inphase_en ? i_sample_i : '0;
  assign calc_bus.q_data = quad_en ? i_sample_q : '0;
  assign calc_bus.src = cmp_src;

  bzcfg_magnitude #(
    .DATA_W(DATA_W)
  ) u_magnitude (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .calc(calc_bus)
  );

  assign cmp_value = calc_bus.value[`BZ_CMP_LSB +: 8];
  assign cmp_valid = calc_bus.done && thr_en;
  assign above = cmp_value > hi_thr_reg;
  assign below = cmp_value < lo_thr_reg;

  // sticky status: events set, a status read clears what it returned, set wins
  always_comb begin
    status_set = 8'h00;
    status_set[`BZ_ST_ABOVE] = cmp_valid && above;
    status_set[`BZ_ST_BELOW] = cmp_valid && below;
    status_set[`BZ_ST_LEADOFF] = leadoff_status && !leadoff_status_d_reg;
    status_set[`BZ_ST_BIAS_RDY] = (bias_cnt_reg == BIAS_END) && !bias_ready_reg;
    status_clr = rd_status ? prdata_reg[7:0] : 8'h00;
    status_next = (status_reg & ~status_clr) | status_set;
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      status_reg <= `BZ_RST_STATUS;
      leadoff_status_d_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      leadoff_status_d_reg <= leadoff_status;
    end
  end

  assign o_irq = |(status_reg & mask_reg);
endmodule // bzcfg_top

// >>> logic/bzcfg_map.svh
// register indices, field positions, reset values and timing counts for the bioz config block
`ifndef BZCFG_MAP_SVH
`define BZCFG_MAP_SVH

// register indices; byte address is four times the index
`define BZ_IDX_STATUS 10'h001
`define BZ_IDX_MASK 10'h002
`define BZ_IDX_CFG1 10'h020
`define BZ_IDX_CFG2 10'h021
`define BZ_IDX_CFG3 10'h022
`define BZ_IDX_LO_THR 10'h026
`define BZ_IDX_HI_THR 10'h027

// channel control 1
`define BZ_C1_INPHASE_EN 0
`define BZ_C1_QUAD_EN 1
`define BZ_C1_BIAS_EN 2
`define BZ_C1_ADC_OSR_LSB 3
`define BZ_C1_DAC_OSR_LSB 6

// filter and threshold config
`define BZ_C2_THR_EN 0
`define BZ_C2_CMP_LSB 1
`define BZ_C2_LPF_LSB 3
`define BZ_C2_HPF_LSB 6

// drive and lead-off config
`define BZ_C3_MODE_LSB 0
`define BZ_C3_IRGE_LSB 2
`define BZ_C3_VMAG_LSB 4
`define BZ_C3_RAPID 6
`define BZ_C3_EXT_RES 7

// status flags and interrupt mask layout
`define BZ_ST_LEADOFF 0
`define BZ_ST_BIAS_RDY 1
`define BZ_ST_BELOW 5
`define BZ_ST_ABOVE 6

// reset values
`define BZ_RST_CFG1 8'h00
`define BZ_RST_CFG2 8'h00
`define BZ_RST_CFG3 8'h00
`define BZ_RST_LO_THR 8'h00
`define BZ_RST_HI_THR 8'h00
`define BZ_RST_MASK 8'h00
`define BZ_RST_STATUS 8'h00

// magnitude bits seen by the 8-bit threshold comparator
`define BZ_CMP_LSB 12

// timing
`define BZ_CLK_PERIOD_NS 25
`define BZ_TICK_NS 1000000
`define BZ_TICK_MS 1
`define BZ_TICK_CYCLES (`BZ_TICK_NS / `BZ_CLK_PERIOD_NS)
`define BZ_BIAS_SETTLE_MS 200
`define BZ_LOFF_WINDOW_MS 128
`define BZ_BIAS_SETTLE_TICKS (`BZ_BIAS_SETTLE_MS / `BZ_TICK_MS)
`define BZ_LOFF_WINDOW_TICKS (`BZ_LOFF_WINDOW_MS / `BZ_TICK_MS)

`endif

// >>> logic/bzcfg_pkg.sv
// types shared by the bioz config block
package bzcfg_pkg;
  localparam int BZCFG_DATA_W = 20;

  typedef logic [7:0] bzcfg_byte_t;

  typedef enum logic [1:0] {
    BZCFG_CMP_INPHASE = 2'b00,
    BZCFG_CMP_QUAD = 2'b01,
    BZCFG_CMP_MAG = 2'b10,
    BZCFG_CMP_RSVD = 2'b11
  } bzcfg_cmp_src_t;

  typedef enum logic [1:0] {
    BZCFG_HP_BYPASS = 2'b00,
    BZCFG_HP_X0P00025 = 2'b01,
    BZCFG_HP_X0P002 = 2'b10
  } bzcfg_hp_cut_t;

  typedef enum logic [2:0] {
    BZCFG_LP_BYPASS = 3'b000,
    BZCFG_LP_X0P005 = 3'b001,
    BZCFG_LP_X0P02 = 3'b010,
    BZCFG_LP_X0P08 = 3'b011,
    BZCFG_LP_X0P25 = 3'b100
  } bzcfg_lp_cut_t;
endpackage

// >>> logic/bzcfg_calc_if.sv
// request and answer between the compare front end and the magnitude engine
`timescale 1ns/1ps
interface bzcfg_calc_if #(parameter int DATA_W = 20);
  logic start;
  logic signed [DATA_W-1:0] i_data;
  logic signed [DATA_W-1:0] q_data;
  bzcfg_pkg::bzcfg_cmp_src_t src;
  logic busy;
  logic done;
  logic [DATA_W-1:0] value;

  modport requester(output start, output i_data, output q_data, output src,
                    input busy, input done, input value);
  modport engine(input start, input i_data, input q_data, input src,
                 output busy, output done, output value);
endinterface

// >>> logic/bzcfg_magnitude.sv
// computes |i|, |q| or sqrt(i^2+q^2) with a fixed bit-serial latency
`timescale 1ns/1ps
module bzcfg_magnitude #(
  parameter int DATA_W = 20
) (
  input wire logic i_clock,
  input wire logic i_srst,
  bzcfg_calc_if.engine calc
);
  import bzcfg_pkg::*;

  localparam int RAD_W = 2 * DATA_W;
  localparam int REM_W = DATA_W + 3;
  localparam int CNT_W = $clog2(DATA_W + 1);
  localparam logic [CNT_W-1:0] LAST_STEP = CNT_W'(DATA_W - 1);

  function automatic logic [DATA_W-1:0] abs_val(input logic signed [DATA_W-1:0] v);
    abs_val = v[DATA_W-1] ? DATA_W'(~v + 1'b1) : DATA_W'(v);
  endfunction

  logic busy_reg;
  logic done_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [RAD_W-1:0] rad_reg;
  logic [REM_W-1:0] rem_reg;
  logic [DATA_W-1:0] root_reg;
  logic [DATA_W-1:0] abs_i_reg;
  logic [DATA_W-1:0] abs_q_reg;
  logic [DATA_W-1:0] value_reg;
  bzcfg_cmp_src_t src_reg;
  logic [DATA_W-1:0] abs_i;
  logic [DATA_W-1:0] abs_q;
  logic [REM_W-1:0] trial_rem;
  logic [REM_W-1:0] trial_sub;
  logic fits;
  logic [DATA_W-1:0] root_next;

  assign abs_i = abs_val(calc.i_data);
  assign abs_q = abs_val(calc.q_data);
  assign trial_rem = {rem_reg[REM_W-3:0], rad_reg[RAD_W-1 -: 2]};
  assign trial_sub = {1'b0, root_reg, 2'b01};
  assign fits = (trial_rem >= trial_sub);
  assign root_next = {root_reg[DATA_W-2:0], fits};

  // sequencing
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      done_reg <= 1'b0;
      if (!busy_reg && calc.start) begin
        busy_reg <= 1'b1;
        cnt_reg <= '0;
      end else if (busy_reg) begin
        if (cnt_reg == LAST_STEP) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end

  // restoring square root, two radicand bits per step
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rad_reg <= '0;
      rem_reg <= '0;
      root_reg <= '0;
      abs_i_reg <= '0;
      abs_q_reg <= '0;
      value_reg <= '0;
      src_reg <= BZCFG_CMP_INPHASE;
    end else if (!busy_reg && calc.start) begin
      abs_i_reg <= abs_i;
      abs_q_reg <= abs_q;
      src_reg <= calc.src;
      rad_reg <= RAD_W'(abs_i) * RAD_W'(abs_i) + RAD_W'(abs_q) * RAD_W'(abs_q);
      rem_reg <= '0;
      root_reg <= '0;
    end else if (busy_reg) begin
      rad_reg <= {rad_reg[RAD_W-3:0], 2'b00};
      rem_reg <= fits ? REM_W'(trial_rem - trial_sub) : trial_rem;
      root_reg <= root_next;
      if (cnt_reg == LAST_STEP) begin
        case (src_reg)
          BZCFG_CMP_INPHASE: value_reg <= abs_i_reg;
          BZCFG_CMP_QUAD: value_reg <= abs_q_reg;
          default: value_reg <= root_next;
        endcase
      end
    end
  end

  assign calc.busy = busy_reg;
  assign calc.done = done_reg;
  assign calc.value = value_reg;
endmodule // bzcfg_magnitude

// >>> logic/bzcfg_debounce.sv
// dc lead-off qualifier: holds off status until the condition lasts the window; with i_rapid set, status follows the condition at once
`timescale 1ns/1ps
module bzcfg_debounce #(
  parameter int WINDOW_TICKS = 128
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_tick,
  input wire logic i_level,
  input wire logic i_rapid,
  output logic o_status
);
  localparam int CNT_W = $clog2(WINDOW_TICKS + 1);
  localparam logic [CNT_W-1:0] WINDOW_END = CNT_W'(WINDOW_TICKS);

  logic [CNT_W-1:0] cnt_reg;
  logic status_reg;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cnt_reg <= '0;
      status_reg <= 1'b0;
    end else if (!i_level) begin
      // any break in the condition restarts the window
      cnt_reg <= '0;
      status_reg <= 1'b0;
    end else if (i_rapid) begin
      status_reg <= 1'b1;
    end else if (cnt_reg == WINDOW_END) begin
      status_reg <= 1'b1;
    end else if (i_tick) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign o_status = status_reg;
endmodule // bzcfg_debounce

// >>> verif/bzcfg_top_chk.sv
// port-level assertions for the bioz config block
`timescale 1ns/1ps
`include "bzcfg_map.svh"
module bzcfg_top_chk #(
  parameter int TICK_CYCLES = 40000,
  parameter int BIAS_SETTLE_TICKS = 200
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_safe_valid,
  input wire logic [1:0] i_safe_voltage_level,
  input wire logic i_leadoff_raw,
  input wire logic o_bias_ref_on,
  input wire logic o_bias_ready,
  input wire logic o_pll_force_on,
  input wire logic o_drive_enable,
  input wire logic o_inphase_rx_enable,
  input wire logic o_quad_rx_enable,
  input wire bzcfg_pkg::bzcfg_hp_cut_t o_hipass_cutoff,
  input wire bzcfg_pkg::bzcfg_lp_cut_t o_lopass_cutoff,
  input wire logic [1:0] o_drive_voltage_level,
  input wire logic o_external_resistor_sel,
  input wire logic o_dc_leadoff_status
);
  import bzcfg_pkg::*;
  localparam int SETTLE_MIN = (BIAS_SETTLE_TICKS - 1) * TICK_CYCLES;
  int on_cnt;
  logic acc;
  assign acc = i_psel && i_penable && i_pwrite;
  // cycles the bias has been on, saturating at the settle minimum
  always_ff @(posedge i_clock) begin
    if (i_srst || !o_bias_ref_on) begin
      on_cnt <= 0;
    end else if (on_cnt < SETTLE_MIN) begin
      on_cnt <= on_cnt + 1;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  property p_force;
    o_pll_force_on |-> o_bias_ref_on && o_drive_enable && (o_inphase_rx_enable || o_quad_rx_enable);
  endproperty
  a_force: assert property (p_force) else $error("pll forced without bias or path");
  property p_ien;
    acc && i_paddr[11:2] == `BZ_IDX_CFG1 |-> ##2 o_inphase_rx_enable == $past(i_pwdata[0], 2);
  endproperty
  a_ien: assert property (p_ien) else $error("in-phase path enable wrong");
  property p_qen;
    acc && i_paddr[11:2] == `BZ_IDX_CFG1 |-> ##2 o_quad_rx_enable == $past(i_pwdata[1], 2);
  endproperty
  a_qen: assert property (p_qen) else $error("quadrature path enable wrong");
  property p_hp;
    acc && i_paddr[11:2] == `BZ_IDX_CFG2 |-> ##2 o_hipass_cutoff == ($past(i_pwdata[7], 2) ?
      BZCFG_HP_X0P002 : $past(i_pwdata[6], 2) ? BZCFG_HP_X0P00025 : BZCFG_HP_BYPASS);
  endproperty
  a_hp: assert property (p_hp) else $error("high-pass decode wrong");
  property p_lp;
    acc && i_paddr[11:2] == `BZ_IDX_CFG2 |-> ##2 o_lopass_cutoff == ($past(i_pwdata[5], 2) ?
      BZCFG_LP_X0P25 : bzcfg_lp_cut_t'({1'b0, $past(i_pwdata[4:3], 2)}));
  endproperty
  a_lp: assert property (p_lp) else $error("low-pass decode wrong");
  property p_vl;
    acc && i_paddr[11:2] == `BZ_IDX_CFG3 && !i_safe_valid |=>
      o_drive_voltage_level == $past(i_pwdata[5:4]);
  endproperty
  a_vl: assert property (p_vl) else $error("voltage level field wrong");
  property p_safe;
    i_safe_valid && !o_external_resistor_sel |=> o_drive_voltage_level == $past(i_safe_voltage_level);
  endproperty
  a_safe: assert property (p_safe) else $error("safety overwrite missing");
  property p_ext;
    i_safe_valid && o_external_resistor_sel && !acc |=> $stable(o_drive_voltage_level);
  endproperty
  a_ext: assert property (p_ext) else $error("level overwritten with external resistor");
  property p_ldrop;
    !i_leadoff_raw [*8] |-> !o_dc_leadoff_status;
  endproperty
  a_ldrop: assert property (p_ldrop) else $error("lead-off status without condition");
  property p_bias;
    $rose(o_bias_ready) |-> on_cnt >= SETTLE_MIN;
  endproperty
  a_bias: assert property (p_bias) else $error("bias ready before settle time");
endmodule // bzcfg_top_chk
bind bzcfg_top bzcfg_top_chk #(.TICK_CYCLES(TICK_CYCLES), .BIAS_SETTLE_TICKS(BIAS_SETTLE_TICKS))
  u_chk (.i_clock, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_safe_valid,
  .i_safe_voltage_level, .i_leadoff_raw, .o_bias_ref_on, .o_bias_ready, .o_pll_force_on,
  .o_drive_enable, .o_inphase_rx_enable, .o_quad_rx_enable, .o_hipass_cutoff, .o_lopass_cutoff,
  .o_drive_voltage_level, .o_external_resistor_sel, .o_dc_leadoff_status);

// >>> verif/tb_bzcfg_top.sv
// self-checking bench for the bioz config block
`timescale 1ns/1ps
`include "bzcfg_map.svh"
module tb_bzcfg_top;
  import bzcfg_pkg::*;
  logic i_clock = 0;
  logic i_srst = 1;
  logic psel = 0, pen = 0, pwr = 0, sv = 0, lo = 0, safe = 0, se;
  logic [11:0] pa = '0;
  logic [31:0] pd = '0, r, prd;
  logic [19:0] si = '0, sq = '0;
  logic [1:0] sl = '0, sc = '0, vl, cr, st;
  logic rdy, err, bon, brdy, pll, drv, irx, qrx, ext, loff, irq;
  bzcfg_hp_cut_t hp;
  bzcfg_lp_cut_t lp;
  logic [7:0] m = '0;
  logic [9:0] ra [7] = '{`BZ_IDX_STATUS, `BZ_IDX_MASK, `BZ_IDX_CFG1, `BZ_IDX_CFG2,
    `BZ_IDX_CFG3, `BZ_IDX_LO_THR, `BZ_IDX_HI_THR};
  logic [7:0] ev [4] = '{8'h01, 8'hfa, 8'h53, 8'h00};
  logic [4:0] ex [4] = '{5'h1e, 5'h1d, 5'h1f, 5'h00}, ov;
  int errors = 0, n_checks = 0, cyc = 0, k;
  always #12.5 i_clock = ~i_clock;
  bzcfg_top #(.TICK_CYCLES(4), .BIAS_SETTLE_TICKS(3), .LOFF_WINDOW_TICKS(3)) dut (
    .i_clock(i_clock), .i_srst(i_srst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(pa), .i_pwdata(pd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
    .i_sample_valid(sv), .i_sample_i(si), .i_sample_q(sq), .i_leadoff_raw(lo),
    .i_safe_valid(safe), .i_safe_voltage_level(sl), .i_safe_current_range(sc),
    .o_bias_ref_on(bon), .o_bias_ready(brdy), .o_pll_force_on(pll), .o_drive_enable(drv),
    .o_inphase_rx_enable(irx), .o_quad_rx_enable(qrx), .o_hipass_cutoff(hp),
    .o_lopass_cutoff(lp), .o_converter_oversample_sel(ov[2:0]), .o_dac_oversample_sel(ov[4:3]),
    .o_drive_voltage_level(vl), .o_drive_current_range(cr), .o_stimulus_type_sel(st),
    .o_external_resistor_sel(ext), .o_dc_leadoff_status(loff), .o_irq(irq));
  task automatic end_of_test();
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask
  // one apb transfer; data to r, error to se
  task automatic apb(input logic w, input logic [9:0] x, input logic [31:0] d);
    @(posedge i_clock);
    psel <= 1;
    pwr <= w;
    pa <= {x, 2'b00};
    pd <= d;
    @(posedge i_clock);
    pen <= 1;
    @(posedge i_clock);
    while (rdy !== 1'b1) @(posedge i_clock);
    r = prd;
    se = err;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic wt(ref logic s, input int lim);
    k = 0;
    while (s !== 1'b1 && k < lim) begin
      @(posedge i_clock);
      k++;
    end
  endtask
  task automatic sp();
    safe <= 1;
    @(posedge i_clock);
    safe <= 0;
    @(posedge i_clock);
  endtask
  // compare one sample, check irq and flags
  task automatic cmp(input logic [7:0] c1, c2, input logic [19:0] i, q, input logic [7:0] x);
    apb(1, `BZ_IDX_CFG1, {24'h0, c1});
    apb(1, `BZ_IDX_CFG2, {24'h0, c2});
    apb(0, `BZ_IDX_STATUS, 0);
    si <= i;
    sq <= q;
    sv <= 1;
    @(posedge i_clock);
    sv <= 0;
    repeat (25) @(posedge i_clock);
    chk("irq", irq, |(x & m));
    apb(0, `BZ_IDX_STATUS, 0);
    chk("flags", r & 32'h60, x);
  endtask
  initial begin
    repeat (4) @(posedge i_clock);
    i_srst <= 0;
    foreach (ra[j]) begin
      apb(0, ra[j], 0);
      chk("reset value", r, 0);
    end
    apb(1, 10'h3f0, 32'hff);
    apb(0, 10'h3f0, 0);
    chk("unmapped err", {rdy, se}, 2'h3);
    chk("unmapped data", r, 0);
    apb(1, `BZ_IDX_HI_THR, 32'h40);
    apb(1, `BZ_IDX_LO_THR, 32'h10);
    apb(0, `BZ_IDX_HI_THR, 0);
    chk("upper", r, 32'h40);
    apb(0, `BZ_IDX_LO_THR, 0);
    chk("lower", r, 32'h10);
    apb(1, `BZ_IDX_CFG1, 32'h04);
    wt(brdy, 60);
    chk("settle", k >= 8 && k < 60, 1);
    chk("bias only", {bon, pll, drv}, 3'h4);
    apb(0, `BZ_IDX_STATUS, 0);
    chk("ready event", r[1], 1);
    apb(1, `BZ_IDX_STATUS, 32'hff);
    apb(0, `BZ_IDX_STATUS, 0);
    chk("status clear", r, 0);
    foreach (ev[j]) begin
      apb(1, `BZ_IDX_CFG1, {24'h0, ev[j]});
      repeat (2) @(posedge i_clock);
      chk("enables", {ov, bon, pll, drv, irx, qrx}, {ev[j][7:3], ex[j]});
    end
    for (int c = 0; c < 8; c++) begin
      apb(1, `BZ_IDX_CFG2, c << 3 | (c & 3) << 6);
      repeat (2) @(posedge i_clock);
      chk("lopass", lp, c > 3 ? 4 : c);
      chk("hipass", hp, (c & 3) == 3 ? 2 : c & 3);
    end
    apb(0, `BZ_IDX_CFG2, 0);
    chk("cfg2", r, 32'hf8);
    m = 8'h60;
    apb(1, `BZ_IDX_MASK, {24'h0, m});
    cmp(8'h03, 8'h01, -20'h50000, 20'h05000, 8'h40);
    cmp(8'h03, 8'h03, -20'h50000, -20'h05000, 8'h20);
    cmp(8'h03, 8'h05, 20'h50000, 20'h05000, 8'h40);
    cmp(8'h03, 8'h07, 20'h50000, 20'h05000, 8'h00);
    cmp(8'h03, 8'h00, 20'h50000, 20'h05000, 8'h00);
    cmp(8'h02, 8'h05, 20'h50000, 20'h20000, 8'h00);
    cmp(8'h01, 8'h05, 20'h08000, -20'h50000, 8'h20);
    cmp(8'h03, 8'h01, 20'h40fff, 20'h10000, 8'h00);
    cmp(8'h03, 8'h03, 20'h40fff, 20'h10000, 8'h00);
    m = 8'h20;
    apb(1, `BZ_IDX_MASK, {24'h0, m});
    cmp(8'h03, 8'h01, 20'h41000, 20'h00000, 8'h40);
    apb(1, `BZ_IDX_CFG3, 32'h3d);
    @(posedge i_clock);
    chk("drive", {ext, vl, cr, st}, 7'h3d);
    sl <= 2'h1;
    sc <= 2'h2;
    sp();
    chk("safe", {vl, cr}, 4'h6);
    apb(0, `BZ_IDX_CFG3, 0);
    chk("cfg3", r, 32'h19);
    apb(1, `BZ_IDX_CFG3, 32'hbc);
    sp();
    chk("ext kept", {ext, vl, cr}, 5'h1f);
    apb(1, `BZ_IDX_MASK, 32'h01);
    apb(1, `BZ_IDX_CFG3, 32'h40);
    lo <= 1;
    wt(loff, 20);
    chk("rapid", k < 10, 1);
    repeat (2) @(posedge i_clock);
    chk("irq on", irq, 1);
    apb(1, `BZ_IDX_MASK, 0);
    @(posedge i_clock);
    chk("irq masked", irq, 0);
    apb(0, `BZ_IDX_STATUS, 0);
    chk("loff event", r[0], 1);
    apb(1, `BZ_IDX_MASK, 32'h01);
    @(posedge i_clock);
    chk("irq cleared", irq, 0);
    lo <= 0;
    repeat (8) @(posedge i_clock);
    chk("loff drop", loff, 0);
    apb(1, `BZ_IDX_CFG3, 0);
    lo <= 1;
    repeat (5) @(posedge i_clock);
    lo <= 0;
    wt(loff, 30);
    chk("short ignored", k, 30);
    lo <= 1;
    wt(loff, 60);
    chk("window", k >= 12 && k < 60, 1);
    lo <= 0;
    end_of_test();
  end
endmodule // tb_bzcfg_top
